// File: src/rsc_pkg.sv
// Package with register map, field positions, reset values and timing for the sequencer
package rsc_pkg;
  // Register offsets
  localparam logic [7:0] RSC_ADDR_LDO0_SEQUENCE_DELAYS   = 8'h0E;
  localparam logic [7:0] RSC_ADDR_LDO1_SEQUENCE_DELAYS   = 8'h0F;
  localparam logic [7:0] RSC_ADDR_FIRST_DELAY  = 8'h10;
  localparam logic [7:0] RSC_ADDR_SECOND_DELAY = 8'h11;
  localparam logic [7:0] RSC_ADDR_GENERAL_OUTPUTS_CONTROL     = 8'h12;
  localparam logic [7:0] RSC_ADDR_CONFIG       = 8'h13;
  localparam logic [7:0] RSC_ADDR_CLK_CTRL     = 8'h14;
  localparam logic [7:0] RSC_ADDR_PG_SETUP     = 8'h15;

  // Reset values
  localparam logic [7:0] RSC_RST_LDO0_SEQUENCE_DELAYS   = 8'h21;
  localparam logic [7:0] RSC_RST_LDO1_SEQUENCE_DELAYS   = 8'h00;
  localparam logic [7:0] RSC_RST_FIRST_DELAY  = 8'h05;
  localparam logic [7:0] RSC_RST_SECOND_DELAY = 8'h0A;
  localparam logic [7:0] RSC_RST_GENERAL_OUTPUTS_CONTROL     = 8'h77;
  localparam logic [7:0] RSC_RST_CONFIG       = 8'h06;
  localparam logic [7:0] RSC_RST_CLK_CTRL     = 8'h01;
  localparam logic [7:0] RSC_RST_PG_SETUP     = 8'h77;

  // Writable bits of the output control register; bits 7 and 3 read zero
  localparam logic [7:0] RSC_GENERAL_OUTPUTS_CONTROL_WMASK   = 8'h77;

  // Delay register fields
  localparam int RSC_ON_LSB  = 0;
  localparam int RSC_OFF_LSB = 4;
  localparam int RSC_CODE_W  = 4;

  // Output control fields
  localparam int RSC_FIRST_LEVEL_BIT  = 0;
  localparam int RSC_FIRST_GATE_BIT   = 1;
  localparam int RSC_FIRST_OD_BIT     = 2;
  localparam int RSC_SECOND_LEVEL_BIT = 4;
  localparam int RSC_SECOND_GATE_BIT  = 5;
  localparam int RSC_SECOND_OD_BIT    = 6;

  // Global configuration fields
  localparam int RSC_SPREAD_BIT     = 0;
  localparam int RSC_TWARN_BIT      = 1;
  localparam int RSC_ENABLE_PIN_PULLDOWN_BIT      = 2;
  localparam int RSC_SHARED_PD_BIT  = 3;
  localparam int RSC_PIN_SEL_BIT    = 4;
  localparam int RSC_OFF_RANGE_BIT  = 5;
  localparam int RSC_ON_RANGE_BIT   = 6;

  // Clock source fields
  localparam int RSC_FREQ_LSB   = 0;
  localparam int RSC_FREQ_W     = 5;
  localparam int RSC_PLL_EN_BIT = 6;

  // Power-good setup fields
  localparam int RSC_PG_SRC_LSB     = 0;
  localparam int RSC_PG_SRC_W       = 4;
  localparam int RSC_PG_WIN_BUCK    = 4;
  localparam int RSC_PG_WIN_LDO     = 5;
  localparam int RSC_PG_OD_BIT      = 6;
  localparam int RSC_PG_POL_BIT     = 7;

  // Sequencing channels
  localparam int RSC_CH_LDO0   = 0;
  localparam int RSC_CH_LDO1   = 1;
  localparam int RSC_CH_FIRST  = 2;
  localparam int RSC_CH_SECOND = 3;
  localparam int RSC_NUM_CH    = 4;

  // Timing: one delay step is half a millisecond
  localparam int RSC_STEP_NS       = 500000;
  localparam int RSC_CLK_PERIOD_NS = 20;
  localparam int RSC_STEP_CYCLES   = RSC_STEP_NS / RSC_CLK_PERIOD_NS;
  localparam int RSC_STEP_CNT_W    = 15;
  localparam int RSC_ELAPSED_W     = 5;
  localparam logic [RSC_ELAPSED_W-1:0] RSC_ELAPSED_MAX = 5'h1F;
endpackage : rsc_pkg

// File: src/rsc_rail_sequencing_control.sv
// Rail sequencing, output control and configuration registers of the regulator
module rsc_rail_sequencing_control
  import rsc_pkg::*;
#(
  parameter int STEP_CYCLES = RSC_STEP_CYCLES
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  srst_in,
  input  wire logic                  enable_pin_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire logic [RSC_PG_SRC_W-1:0] rail_valid_in,
  output logic                       ldo0_on_out,
  output logic                       ldo1_on_out,
  output logic                       first_general_output_out,
  output logic                       first_general_output_oe_out,
  output logic                       second_general_output_out,
  output logic                       second_general_output_oe_out,
  output logic                       shared_pin_clock_mode_out,
  output logic                       shared_pin_pulldown_out,
  output logic                       enable_pin_pulldown_out,
  output logic                       thermal_warning_threshold_out,
  output logic                       spread_spectrum_enable_out,
  output logic                       pll_enable_out,
  output logic [RSC_FREQ_W-1:0]      external_clock_frequency_code_out,
  output logic                       linear_rail_window_monitor_out,
  output logic                       buck_rail_window_monitor_out,
  output logic                       power_good_output_out,
  output logic                       power_good_output_oe_out
);

  logic [7:0]                ldo0_sequence_delays_reg;
  logic [7:0]                ldo1_sequence_delays_reg;
  logic [7:0]                first_delay_reg;
  logic [7:0]                second_delay_reg;
  logic [7:0]                general_outputs_control_reg;
  logic [7:0]                config_reg;
  logic [7:0]                clk_ctrl_reg;
  logic [7:0]                pg_setup_reg;
  logic [7:0]                rdata_next;
  logic                      enable_prev_reg;
  logic                      enable_edge;
  logic [RSC_STEP_CNT_W-1:0] step_cnt_reg;
  logic [RSC_ELAPSED_W-1:0]  elapsed_reg;
  logic [RSC_NUM_CH-1:0]     seq_on_reg;
  logic [7:0]                delay_regs [RSC_NUM_CH];
  logic                      first_level;
  logic                      second_level;
  logic                      power_good;

  // Register writes; the reserved clock bit is stored as written
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ldo0_sequence_delays_reg   <= RSC_RST_LDO0_SEQUENCE_DELAYS;
      ldo1_sequence_delays_reg   <= RSC_RST_LDO1_SEQUENCE_DELAYS;
      first_delay_reg  <= RSC_RST_FIRST_DELAY;
      second_delay_reg <= RSC_RST_SECOND_DELAY;
      general_outputs_control_reg     <= RSC_RST_GENERAL_OUTPUTS_CONTROL;
      config_reg       <= RSC_RST_CONFIG;
      clk_ctrl_reg     <= RSC_RST_CLK_CTRL;
      pg_setup_reg     <= RSC_RST_PG_SETUP;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        RSC_ADDR_LDO0_SEQUENCE_DELAYS:   ldo0_sequence_delays_reg   <= reg_wdata_in;
        RSC_ADDR_LDO1_SEQUENCE_DELAYS:   ldo1_sequence_delays_reg   <= reg_wdata_in;
        RSC_ADDR_FIRST_DELAY:  first_delay_reg  <= reg_wdata_in;
        RSC_ADDR_SECOND_DELAY: second_delay_reg <= reg_wdata_in;
        RSC_ADDR_GENERAL_OUTPUTS_CONTROL:     general_outputs_control_reg     <= reg_wdata_in & RSC_GENERAL_OUTPUTS_CONTROL_WMASK;
        RSC_ADDR_CONFIG:       config_reg       <= reg_wdata_in;
        RSC_ADDR_CLK_CTRL:     clk_ctrl_reg     <= reg_wdata_in;
        RSC_ADDR_PG_SETUP:     pg_setup_reg     <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr_in)
      RSC_ADDR_LDO0_SEQUENCE_DELAYS:   rdata_next = ldo0_sequence_delays_reg;
      RSC_ADDR_LDO1_SEQUENCE_DELAYS:   rdata_next = ldo1_sequence_delays_reg;
      RSC_ADDR_FIRST_DELAY:  rdata_next = first_delay_reg;
      RSC_ADDR_SECOND_DELAY: rdata_next = second_delay_reg;
      RSC_ADDR_GENERAL_OUTPUTS_CONTROL:     rdata_next = general_outputs_control_reg;
      RSC_ADDR_CONFIG:       rdata_next = config_reg;
      RSC_ADDR_CLK_CTRL:     rdata_next = clk_ctrl_reg;
      RSC_ADDR_PG_SETUP:     rdata_next = pg_setup_reg;
      default:               rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end
  end

  // Enable pin edge detection
  assign enable_edge = enable_pin_in ^ enable_prev_reg;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      enable_prev_reg <= 1'b0;
    end else begin
      enable_prev_reg <= enable_pin_in;
    end
  end

  // Half-ms steps elapsed since the last enable edge, saturating
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      step_cnt_reg <= '0;
      elapsed_reg  <= RSC_ELAPSED_MAX;
    end else if (enable_edge) begin
      step_cnt_reg <= '0;
      elapsed_reg  <= '0;
    end else if (step_cnt_reg == RSC_STEP_CNT_W'(STEP_CYCLES - 1)) begin
      step_cnt_reg <= '0;
      if (elapsed_reg != RSC_ELAPSED_MAX) begin
        elapsed_reg <= elapsed_reg + 1'b1;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end

  assign delay_regs[RSC_CH_LDO0]   = ldo0_sequence_delays_reg;
  assign delay_regs[RSC_CH_LDO1]   = ldo1_sequence_delays_reg;
  assign delay_regs[RSC_CH_FIRST]  = first_delay_reg;
  assign delay_regs[RSC_CH_SECOND] = second_delay_reg;

  // Per-channel sequenced enable; long range doubles the step count
  for (genvar ch = 0; ch < RSC_NUM_CH; ch++) begin : g_seq
    logic [RSC_CODE_W-1:0]    on_code;
    logic [RSC_CODE_W-1:0]    off_code;
    logic [RSC_ELAPSED_W-1:0] on_target;
    logic [RSC_ELAPSED_W-1:0] off_target;

    assign on_code    = delay_regs[ch][RSC_ON_LSB +: RSC_CODE_W];
    assign off_code   = delay_regs[ch][RSC_OFF_LSB +: RSC_CODE_W];
    assign on_target  = config_reg[RSC_ON_RANGE_BIT] ? {on_code, 1'b0}
                                                     : {1'b0, on_code};
    assign off_target = config_reg[RSC_OFF_RANGE_BIT] ? {off_code, 1'b0}
                                                      : {1'b0, off_code};

    always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
        seq_on_reg[ch] <= 1'b0;
      end else if (!enable_edge) begin
        if (enable_prev_reg && elapsed_reg >= on_target) begin
          seq_on_reg[ch] <= 1'b1;
        end else if (!enable_prev_reg && elapsed_reg >= off_target) begin
          seq_on_reg[ch] <= 1'b0;
        end
      end
    end
  end

  assign ldo0_on_out = seq_on_reg[RSC_CH_LDO0];
  assign ldo1_on_out = seq_on_reg[RSC_CH_LDO1];

  // General outputs: level bit, optionally ANDed with the sequenced enable
  assign first_level = general_outputs_control_reg[RSC_FIRST_LEVEL_BIT] &
                       (~general_outputs_control_reg[RSC_FIRST_GATE_BIT] | seq_on_reg[RSC_CH_FIRST]);
  assign second_level = general_outputs_control_reg[RSC_SECOND_LEVEL_BIT] &
                        (~general_outputs_control_reg[RSC_SECOND_GATE_BIT] | seq_on_reg[RSC_CH_SECOND]);

  // Open-drain drives only the low level
  assign first_general_output_out    = first_level;
  assign first_general_output_oe_out = ~general_outputs_control_reg[RSC_FIRST_OD_BIT] | ~first_level;

  assign shared_pin_clock_mode_out    = config_reg[RSC_PIN_SEL_BIT];
  assign second_general_output_out    = second_level & ~config_reg[RSC_PIN_SEL_BIT];
  assign second_general_output_oe_out = ~config_reg[RSC_PIN_SEL_BIT] &
                                        (~general_outputs_control_reg[RSC_SECOND_OD_BIT] | ~second_level);

  assign enable_pin_pulldown_out       = config_reg[RSC_ENABLE_PIN_PULLDOWN_BIT];
  assign shared_pin_pulldown_out       = config_reg[RSC_SHARED_PD_BIT];
  assign thermal_warning_threshold_out = config_reg[RSC_TWARN_BIT];
  assign spread_spectrum_enable_out    = config_reg[RSC_SPREAD_BIT];
  assign pll_enable_out                = clk_ctrl_reg[RSC_PLL_EN_BIT];
  assign external_clock_frequency_code_out = clk_ctrl_reg[RSC_FREQ_LSB +: RSC_FREQ_W];

  assign linear_rail_window_monitor_out = pg_setup_reg[RSC_PG_WIN_LDO];
  assign buck_rail_window_monitor_out   = pg_setup_reg[RSC_PG_WIN_BUCK];

  // Unselected rails count as valid
  assign power_good = &(rail_valid_in | ~pg_setup_reg[RSC_PG_SRC_LSB +: RSC_PG_SRC_W]);

  assign power_good_output_out    = power_good ^ pg_setup_reg[RSC_PG_POL_BIT];
  assign power_good_output_oe_out = ~pg_setup_reg[RSC_PG_OD_BIT] | ~power_good_output_out;

endmodule // rsc_rail_sequencing_control

// File: tb/rsc_port_checker_properties.sv
// Port checker of the sequencing block, tracking its control registers from writes
module rsc_port_checker
  import rsc_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       srst_in,
  input wire logic       enable_pin_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic [3:0] rail_valid_in,
  input wire logic       ldo0_on_out,
  input wire logic       first_general_output_out,
  input wire logic       first_general_output_oe_out,
  input wire logic       second_general_output_out,
  input wire logic       second_general_output_oe_out,
  input wire logic       shared_pin_clock_mode_out,
  input wire logic       enable_pin_pulldown_out,
  input wire logic       thermal_warning_threshold_out,
  input wire logic       spread_spectrum_enable_out,
  input wire logic       pll_enable_out,
  input wire logic       shared_pin_pulldown_out,
  input wire logic       linear_rail_window_monitor_out,
  input wire logic       buck_rail_window_monitor_out,
  input wire logic [4:0] external_clock_frequency_code_out,
  input wire logic       power_good_output_oe_out,
  input wire logic       power_good_output_out
);
  logic [7:0] ctl_reg;
  logic [7:0] cfg_reg;
  logic [7:0] clk_reg;
  logic [7:0] pg_reg;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctl_reg <= 8'h77;
      cfg_reg <= 8'h06;
      clk_reg <= 8'h01;
      pg_reg  <= 8'h77;
    end else if (reg_wr_in) begin
      if (reg_addr_in == RSC_ADDR_GENERAL_OUTPUTS_CONTROL) ctl_reg <= reg_wdata_in;
      if (reg_addr_in == RSC_ADDR_CONFIG) cfg_reg <= reg_wdata_in;
      if (reg_addr_in == RSC_ADDR_CLK_CTRL) clk_reg <= reg_wdata_in;
      if (reg_addr_in == RSC_ADDR_PG_SETUP) pg_reg <= reg_wdata_in;
    end
  end
  a_pg_level: assert property (
    power_good_output_out == ((&(~pg_reg[3:0] | rail_valid_in)) ^ pg_reg[7]))
    else $error("power good level wrong");
  a_enpd_follow: assert property (enable_pin_pulldown_out == cfg_reg[2])
    else $error("enable pull-down wrong");
  a_twarn_follow: assert property (thermal_warning_threshold_out == cfg_reg[1])
    else $error("thermal level wrong");
  a_spread_follow: assert property (spread_spectrum_enable_out == cfg_reg[0])
    else $error("spread spectrum wrong");
  a_pll_follow: assert property (pll_enable_out == clk_reg[6])
    else $error("pll enable wrong");
  a_sharedpd_follow: assert property (shared_pin_pulldown_out == cfg_reg[3])
    else $error("shared pin pull-down wrong");
  a_window_follow: assert property (linear_rail_window_monitor_out == pg_reg[5] &&
    buck_rail_window_monitor_out == pg_reg[4])
    else $error("window monitor select wrong");
  a_freq_follow: assert property (external_clock_frequency_code_out == clk_reg[4:0])
    else $error("clock frequency code wrong");
  a_pg_drive: assert property (
    power_good_output_oe_out == (!pg_reg[6] || !power_good_output_out))
    else $error("power good drive wrong");
  a_second_ungated: assert property (
    !ctl_reg[5] |-> second_general_output_out == (ctl_reg[4] && !cfg_reg[4]))
    else $error("second output level wrong");
  a_second_drive: assert property (!shared_pin_clock_mode_out |->
    second_general_output_oe_out == (!ctl_reg[6] || !second_general_output_out))
    else $error("second output drive wrong");
  a_pin_function: assert property (shared_pin_clock_mode_out |->
    !second_general_output_oe_out && !second_general_output_out)
    else $error("shared pin driven in clock mode");
  a_first_ungated: assert property (!ctl_reg[1] |-> first_general_output_out == ctl_reg[0])
    else $error("first output level wrong");
  a_first_drive: assert property (
    first_general_output_oe_out == (!ctl_reg[2] || !first_general_output_out))
    else $error("first output drive wrong");
  a_ldo_rise: assert property ($rose(ldo0_on_out) |-> $past(enable_pin_in, 2))
    else $error("ldo0 on without enable");
  a_ldo_fall: assert property ($fell(ldo0_on_out) |-> !$past(enable_pin_in, 2))
    else $error("ldo0 off with enable");
  c_ldo_on: cover property ($rose(ldo0_on_out));
  c_ldo_off: cover property ($fell(ldo0_on_out));
  c_clock_mode: cover property (shared_pin_clock_mode_out && reg_wr_in);
endmodule // rsc_port_checker
bind rsc_rail_sequencing_control rsc_port_checker chk_u (.*);

// File: tb/rsc_host_model.sv
// Host model: drives the enable pin and register strobes on the falling clock edge
module rsc_host_model
  import rsc_pkg::*;
(
  input  wire logic  core_clk_in,
  output logic       enable_pin_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic       reg_wr_out,
  output logic       reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    enable_pin_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  task automatic en(input logic v);
    @(negedge core_clk_in);
    enable_pin_out <= v;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    if (a == RSC_ADDR_CLK_CTRL) d[5] = 1'b0;
    if (a == RSC_ADDR_CLK_CTRL && d[4:0] > 5'h17) d[4:0] = 5'h17;
    @(negedge core_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= w;
    reg_rd_out <= !w;
    @(negedge core_clk_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
endmodule // rsc_host_model

// File: tb/test_rail_sequencing_control.sv
// Self-checking bench of the rail sequencing block
module test_rail_sequencing_control
  import rsc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 4;
  int          seed = 32'h8086;
  int          cyc = 0;
  int          fails = 0;
  int          n_compared = 0;
  logic        core_clk_in, srst_in, enable_pin_in, reg_wr_in, reg_rd_in;
  logic        last_on = 1'b0;
  logic [3:0]  rail_valid_in;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [7:0]  exp_rd[$];
  logic [31:0] exp_ev[$];
  logic        ldo0_on_out, ldo1_on_out, first_general_output_out, first_general_output_oe_out;
  logic        second_general_output_out, second_general_output_oe_out, shared_pin_clock_mode_out;
  logic        shared_pin_pulldown_out, enable_pin_pulldown_out, thermal_warning_threshold_out;
  logic        spread_spectrum_enable_out, pll_enable_out, linear_rail_window_monitor_out;
  logic        buck_rail_window_monitor_out, power_good_output_out, power_good_output_oe_out;
  logic [4:0]  external_clock_frequency_code_out;
  rsc_host_model host_u (.core_clk_in(core_clk_in), .enable_pin_out(enable_pin_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in));
  rsc_rail_sequencing_control #(.STEP_CYCLES(S)) dut_u (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic seq(input logic [7:0] dly, input logic [1:0] rng);
    logic [7:0] ctl;
    logic [7:0] cfg;
    logic [7:0] pg;
    int         t;
    ctl = $random(seed);
    cfg = $random(seed);
    pg = $random(seed);
    cfg[7:5] = {1'b0, rng};
    rail_valid_in = 4'($random(seed));
    host_u.xfer(RSC_ADDR_LDO0_SEQUENCE_DELAYS, dly, 1'b1);
    host_u.xfer(RSC_ADDR_GENERAL_OUTPUTS_CONTROL, ctl, 1'b1);
    host_u.xfer(RSC_ADDR_CONFIG, cfg, 1'b1);
    host_u.xfer(RSC_ADDR_PG_SETUP, pg, 1'b1);
    host_u.xfer(RSC_ADDR_CLK_CTRL, pg, 1'b1);
    exp_rd.push_back(cfg);
    host_u.xfer(RSC_ADDR_CONFIG, 8'h00, 1'b0);
    for (int e = 1; e >= 0; e--) begin
      t = e ? dly[3:0] * (rng[1] + 1) : dly[7:4] * (rng[0] + 1);
      host_u.en(e[0]);
      exp_ev.push_back({cyc[30:0] + 31'(2 + t * S), e[0]});
      repeat (34 * S) @(negedge core_clk_in);
      check("first output", first_general_output_out, ctl[0] & (~ctl[1] | e[0]));
      check("second output", second_general_output_out, ~cfg[4] & ctl[4] & (~ctl[5] | e[0]));
      check("ldo1 on", ldo1_on_out, e[0]);
      check("power good", power_good_output_out, (&(~pg[3:0] | rail_valid_in)) ^ pg[7]);
    end
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  // Results are taken off the queues in the order they were noted
  always @(negedge core_clk_in) begin
    if (!srst_in && reg_rd_in) check("read data", reg_rdata_out, exp_rd.pop_front());
    if (!srst_in && ldo0_on_out !== last_on) begin
      check("ldo0 switch", {cyc[30:0], ldo0_on_out}, exp_ev.pop_front());
      last_on = ldo0_on_out;
    end
  end
  initial begin
    logic [7:0] rv [9];
    logic [7:0] d;
    rv = '{8'h21, 8'h00, 8'h05, 8'h0A, 8'h77, 8'h06, 8'h01, 8'h77, 8'h00};
    srst_in = 1'b1;
    rail_valid_in = 4'hF;
    repeat (3) @(negedge core_clk_in);
    srst_in = 1'b0;
    for (int i = 0; i < 9; i++) begin
      exp_rd.push_back(rv[i]);
      host_u.xfer(i < 8 ? 8'h0E + 8'(i) : 8'h20, 8'h00, 1'b0);
    end
    host_u.xfer(RSC_ADDR_GENERAL_OUTPUTS_CONTROL, 8'hFF, 1'b1);
    exp_rd.push_back(8'h77);
    host_u.xfer(RSC_ADDR_GENERAL_OUTPUTS_CONTROL, 8'h00, 1'b0);
    $display("test done: register defaults");
    for (int r = 0; r < 6; r++) begin
      d = $random(seed);
      seq(r == 4 ? 8'hFF : (r == 5 ? 8'h00 : d), r[1:0]);
    end
    $display("test done: sequencing");
    host_u.xfer(RSC_ADDR_LDO0_SEQUENCE_DELAYS, 8'h3F, 1'b1);
    host_u.en(1'b1);
    repeat (3) @(negedge core_clk_in);
    host_u.en(1'b0);
    repeat (40 * S) @(negedge core_clk_in);
    check("queued switches", exp_ev.size(), 0);
    $display("test done: short enable pulse");
    end_of_test();
  end
endmodule // test_rail_sequencing_control
